// ### rtl/rdc_consts.vh
// Register map, field positions, reset values and loop timing constants.
`ifndef RDC_CONSTS_VH
`define RDC_CONSTS_VH

// ---------------------------------------------------------------------------
// Register indices; the byte address on the bus is four times the index.
// ---------------------------------------------------------------------------
`define RDC_IDX_OFFSET_CTRL 10'h02e
`define RDC_IDX_STATUS 10'h02f
`define RDC_IDX_LEVEL_CTRL 10'h030

// ---------------------------------------------------------------------------
// Reset values.
// ---------------------------------------------------------------------------
`define RDC_OFFSET_CTRL_RST 32'h0000_0000
`define RDC_LEVEL_CTRL_RST 32'h0000_0000

// ---------------------------------------------------------------------------
// Offset control register fields (least significant bit of each).
// ---------------------------------------------------------------------------
`define RDC_OTRK_LSB 30
`define RDC_OINIT_LSB 28
`define RDC_OWAIT_LSB 26
`define RDC_OTH_LSB 24
`define RDC_OITER_LSB 22
`define RDC_OSLOW_BIT 21
`define RDC_OFAST_BIT 20
`define RDC_OQ_LSB 10
`define RDC_OI_LSB 0

// ---------------------------------------------------------------------------
// Level control register fields.
// ---------------------------------------------------------------------------
`define RDC_LDEMOD_BIT 31
`define RDC_LCNTZ_BIT 30
`define RDC_LOVR_BIT 29
`define RDC_LTRK_LSB 27
`define RDC_LINIT_LSB 25
`define RDC_LSKIP_LSB 23
`define RDC_LHYST_LSB 17
`define RDC_LTGT_LSB 7
`define RDC_LOVAL_LSB 0

// ---------------------------------------------------------------------------
// Status register fields.
// ---------------------------------------------------------------------------
`define RDC_SQ_LSB 10
`define RDC_SI_LSB 0
`define RDC_SDONE_BIT 20
`define RDC_SDET_BIT 21
`define RDC_SCNT_LSB 22

// ---------------------------------------------------------------------------
// Loop scaling: selector code n gives 2^(base+n) samples, cycles or units.
// ---------------------------------------------------------------------------
`define RDC_AVG_BASE_LOG2 3'h2
`define RDC_WAIT_BASE_LOG2 3
`define RDC_TH_BASE_LOG2 2
`define RDC_COARSE_STEP 10'h020
`define RDC_COARSE_FACTOR_LOG2 2
`define RDC_AXI_OKAY 2'b00
`define RDC_AXI_SLVERR 2'b10

`endif

// ### rtl/rdc_rx_loops.v
// Receiver DC-offset and signal-level loop control with an AXI4-Lite register slave.
`default_nettype none
`include "rdc_consts.vh"

// Summary of operation
// [R1] Track-phase offset averaging length selectable by two bits.
// [R2] Initial-phase offset averaging length selectable separately.
// [R3] Settle wait after each offset DAC update.
// [R4] Two-bit threshold decides offset DAC adjustments.
// [R5] Fast offset mode stops at maximum iteration count.
// [R6] Slow offset mode runs before card response.
// [R7] Enable bit switches on fast offset iteration.
// [R8] Q DAC starts at field; fixed when loops off.
// [R9] I DAC starts at field; fixed when loops off.
// [R10] Upper five bits coarse DAC, lower five fine.
// [R11] Force bit holds demodulator enable asserted.
// [R12] Force bit holds gain update count at zero.
// [R13] Override bit selects override detect threshold value.
// [R14] Track-phase level averaging length selectable.
// [R15] Initial-phase level averaging length selectable.
// [R16] Discard selectable level samples before averaging.
// [R17] Regulate level to target within hysteresis band.
// [R18] Receiver control rewrites override value unless disabled.
// [R19] Selector codes map to increasing power-of-two counts.
module rdc_rx_loops (
    input wire clk_in,                      // 250 MHz clock.
    input wire reset_n_in,                  // Asynchronous reset, active low.
    input wire [11:0] s_axi_awaddr_in,      // Write address.
    input wire s_axi_awvalid_in,            // Write address valid.
    output wire s_axi_awready_out,          // Write address ready.
    input wire [31:0] s_axi_wdata_in,       // Write data.
    input wire [3:0] s_axi_wstrb_in,        // Write byte strobes.
    input wire s_axi_wvalid_in,             // Write data valid.
    output wire s_axi_wready_out,           // Write data ready.
    output wire [1:0] s_axi_bresp_out,      // Write response.
    output wire s_axi_bvalid_out,           // Write response valid.
    input wire s_axi_bready_in,             // Write response ready.
    input wire [11:0] s_axi_araddr_in,      // Read address.
    input wire s_axi_arvalid_in,            // Read address valid.
    output wire s_axi_arready_out,          // Read address ready.
    output wire [31:0] s_axi_rdata_out,     // Read data.
    output wire [1:0] s_axi_rresp_out,      // Read response.
    output wire s_axi_rvalid_out,           // Read data valid.
    input wire s_axi_rready_in,             // Read data ready.
    input wire rx_active_in,                // Receive window open, level.
    input wire card_response_in,            // Card response has begun, level.
    input wire [19:0] adc_iq_in,            // Signed ADC samples, Q in [19:10], I in [9:0].
    input wire adc_valid_in,                // ADC sample strobe.
    input wire [9:0] level_in,              // Unsigned signal-strength sample.
    input wire level_valid_in,              // Signal-strength sample strobe.
    input wire [6:0] detect_threshold_auto_in, // Internally derived detect threshold.
    input wire automatic_receiver_control_on_in, // Receiver control algorithm enabled.
    input wire [6:0] dyn_threshold_in,      // Threshold from power-control voltage.
    input wire dyn_threshold_write_in,      // Strobe to rewrite the override value.
    output reg [4:0] dac_i_coarse_out,      // I coarse offset DAC.
    output reg [4:0] dac_i_fine_out,        // I fine offset DAC.
    output reg [4:0] dac_q_coarse_out,      // Q coarse offset DAC.
    output reg [4:0] dac_q_fine_out,        // Q fine offset DAC.
    output reg demod_enable_out,            // Demodulator enable.
    output reg [6:0] detect_threshold_out,  // Signal detect threshold in use.
    output reg gain_up_out,                 // Pulse: raise receiver gain.
    output reg gain_down_out,               // Pulse: lower receiver gain.
    output reg [7:0] gain_update_count_out  // Number of gain updates in session.
);

    // -----------------------------------------------------------------------
    // Reset synchroniser.
    // -----------------------------------------------------------------------
    reg rst_meta_r;
    reg rst_n_r;
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // -----------------------------------------------------------------------
    // AXI4-Lite slave and registers.
    // -----------------------------------------------------------------------
    reg [31:0] ofs_ctrl_r;
    reg [31:0] lvl_ctrl_r;
    reg aw_have_r;
    reg w_have_r;
    reg [9:0] aw_idx_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg bvalid_r;
    reg [1:0] bresp_r;
    reg rvalid_r;
    reg [31:0] rdata_r;
    reg [1:0] rresp_r;
    wire [31:0] status_w;
    wire wr_go = aw_have_r && w_have_r && !bvalid_r;
    wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    wire [9:0] ar_idx = s_axi_araddr_in[11:2];

    assign s_axi_awready_out = !aw_have_r;
    assign s_axi_wready_out = !w_have_r;
    assign s_axi_bvalid_out = bvalid_r;
    assign s_axi_bresp_out = bresp_r;
    assign s_axi_arready_out = !rvalid_r;
    assign s_axi_rvalid_out = rvalid_r;
    assign s_axi_rdata_out = rdata_r;
    assign s_axi_rresp_out = rresp_r;

    always @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_idx_r <= 10'h000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= `RDC_AXI_OKAY;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `RDC_AXI_OKAY;
            ofs_ctrl_r <= `RDC_OFFSET_CTRL_RST;
            lvl_ctrl_r <= `RDC_LEVEL_CTRL_RST;
        end else begin
            if (s_axi_awvalid_in && !aw_have_r) begin
                aw_have_r <= 1'b1;
                aw_idx_r <= s_axi_awaddr_in[11:2];
            end
            if (s_axi_wvalid_in && !w_have_r) begin
                w_have_r <= 1'b1;
                wdata_r <= s_axi_wdata_in;
                wstrb_r <= s_axi_wstrb_in;
            end
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= `RDC_AXI_OKAY;
                if (aw_idx_r == `RDC_IDX_OFFSET_CTRL) begin
                    ofs_ctrl_r <= (ofs_ctrl_r & ~wmask) | (wdata_r & wmask);
                end else if (aw_idx_r == `RDC_IDX_LEVEL_CTRL) begin
                    lvl_ctrl_r <= (lvl_ctrl_r & ~wmask) | (wdata_r & wmask);
                end else if (aw_idx_r != `RDC_IDX_STATUS) begin
                    bresp_r <= `RDC_AXI_SLVERR;
                end
            end else if (bvalid_r && s_axi_bready_in) begin
                bvalid_r <= 1'b0;
            end
            // The receiver control algorithm's rewrite is applied last, so it wins.
            if (automatic_receiver_control_on_in && dyn_threshold_write_in) begin
                lvl_ctrl_r[`RDC_LOVAL_LSB +: 7] <= dyn_threshold_in; // [R18]
            end
            if (s_axi_arvalid_in && !rvalid_r) begin
                rvalid_r <= 1'b1;
                rresp_r <= `RDC_AXI_OKAY;
                if (ar_idx == `RDC_IDX_OFFSET_CTRL) begin
                    rdata_r <= ofs_ctrl_r;
                end else if (ar_idx == `RDC_IDX_LEVEL_CTRL) begin
                    rdata_r <= lvl_ctrl_r;
                end else if (ar_idx == `RDC_IDX_STATUS) begin
                    rdata_r <= status_w;
                end else begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= `RDC_AXI_SLVERR;
                end
            end else if (rvalid_r && s_axi_rready_in) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------------
    // Field decode.
    // -----------------------------------------------------------------------
    wire [1:0] o_trk = ofs_ctrl_r[`RDC_OTRK_LSB +: 2];
    wire [1:0] o_init = ofs_ctrl_r[`RDC_OINIT_LSB +: 2];
    wire [1:0] o_wait = ofs_ctrl_r[`RDC_OWAIT_LSB +: 2];
    wire [1:0] o_th = ofs_ctrl_r[`RDC_OTH_LSB +: 2];
    wire [1:0] o_iter = ofs_ctrl_r[`RDC_OITER_LSB +: 2];
    wire o_slow = ofs_ctrl_r[`RDC_OSLOW_BIT];
    wire o_fast = ofs_ctrl_r[`RDC_OFAST_BIT];
    wire [19:0] o_start = ofs_ctrl_r[`RDC_OI_LSB +: 20];
    wire [1:0] l_trk = lvl_ctrl_r[`RDC_LTRK_LSB +: 2];
    wire [1:0] l_init = lvl_ctrl_r[`RDC_LINIT_LSB +: 2];
    wire [1:0] l_skip = lvl_ctrl_r[`RDC_LSKIP_LSB +: 2];
    wire [5:0] l_hyst = lvl_ctrl_r[`RDC_LHYST_LSB +: 6];
    wire [9:0] l_tgt = lvl_ctrl_r[`RDC_LTGT_LSB +: 10];

    // -----------------------------------------------------------------------
    // Offset loop control.
    // -----------------------------------------------------------------------
    localparam O_IDLE = 3'd0;
    localparam O_HOLD = 3'd1;
    localparam O_WAIT = 3'd2;
    localparam O_ACC = 3'd3;
    localparam O_ADJ = 3'd4;

    reg [2:0] o_state_r;
    reg o_track_r;
    reg [3:0] o_iter_r;
    reg [6:0] o_wait_r;
    reg [5:0] o_cnt_r;
    reg rx_active_d_r;
    wire rx_rise = rx_active_in && !rx_active_d_r;
    wire slow_window = rx_active_in && !card_response_in && o_slow; // [R6]
    wire [2:0] o_shift = `RDC_AVG_BASE_LOG2 + (o_track_r ? o_trk : o_init); // [R1] [R2] [R19]
    wire [5:0] o_nsamp = 6'h01 << o_shift;
    wire [6:0] o_nwait = 7'h01 << (`RDC_WAIT_BASE_LOG2 + o_wait); // [R3] [R19]
    wire [15:0] o_thr = 16'h0001 << (`RDC_TH_BASE_LOG2 + o_th); // [R4]
    wire [3:0] o_max = 4'h1 << o_iter; // [R5]
    wire [1:0] ch_in_band;
    wire [19:0] dac_w;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            reg signed [15:0] acc_r;
            reg [9:0] dac_r;
            wire signed [15:0] avg = acc_r >>> o_shift;
            wire [15:0] mag = avg[15] ? (~avg + 16'h0001) : avg;
            wire over = mag > o_thr; // [R4]
            wire big = mag > (o_thr << `RDC_COARSE_FACTOR_LOG2);
            wire [9:0] step = (big && !o_track_r) ? `RDC_COARSE_STEP : 10'h001;
            assign ch_in_band[ch] = !over;
            assign dac_w[ch*10 +: 10] = dac_r;
            always @(posedge clk_in or negedge rst_n_r) begin
                if (!rst_n_r) begin
                    acc_r <= 16'h0000;
                    dac_r <= 10'h000;
                end else begin
                    if (o_state_r == O_IDLE || (rx_rise && (o_fast || o_slow))) begin
                        dac_r <= o_start[ch*10 +: 10]; // [R8] [R9]
                    end else if (o_state_r == O_ADJ && over) begin
                        // Positive residual offset pulls the DAC down, saturating at the ends.
                        if (!avg[15]) begin
                            dac_r <= (dac_r > step) ? dac_r - step : 10'h000;
                        end else begin
                            dac_r <= (dac_r < 10'h3ff - step) ? dac_r + step : 10'h3ff;
                        end
                    end
                    if (o_state_r != O_ACC) begin
                        acc_r <= 16'h0000;
                    end else if (adc_valid_in) begin
                        acc_r <= acc_r + {{6{adc_iq_in[ch*10+9]}}, adc_iq_in[ch*10 +: 10]};
                    end
                end
            end
        end
    endgenerate

    always @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_state_r <= O_IDLE;
            o_track_r <= 1'b0;
            o_iter_r <= 4'h0;
            o_wait_r <= 7'h00;
            o_cnt_r <= 6'h00;
            rx_active_d_r <= 1'b0;
        end else begin
            rx_active_d_r <= rx_active_in;
            if (!o_fast && !o_slow) begin
                o_state_r <= O_IDLE; // [R8] [R9]
            end else if (rx_rise) begin
                o_iter_r <= 4'h0;
                o_wait_r <= 7'h00;
                o_track_r <= !o_fast;
                o_state_r <= (o_fast || slow_window) ? O_WAIT : O_HOLD; // [R7]
            end else begin
                case (o_state_r)
                    O_IDLE: begin
                        o_state_r <= O_HOLD;
                    end
                    O_HOLD: begin
                        if (slow_window) begin
                            o_track_r <= 1'b1;
                            o_wait_r <= 7'h00;
                            o_state_r <= O_WAIT;
                        end
                    end
                    O_WAIT: begin
                        if (o_track_r && !slow_window) begin
                            o_state_r <= O_HOLD;
                        end else if (o_wait_r >= o_nwait - 7'h01) begin
                            o_cnt_r <= 6'h00;
                            o_state_r <= O_ACC; // [R3]
                        end else begin
                            o_wait_r <= o_wait_r + 7'h01;
                        end
                    end
                    O_ACC: begin
                        if (o_track_r && !slow_window) begin
                            o_state_r <= O_HOLD;
                        end else if (adc_valid_in) begin
                            o_cnt_r <= o_cnt_r + 6'h01;
                            if (o_cnt_r == o_nsamp - 6'h01) begin
                                o_state_r <= O_ADJ;
                            end
                        end
                    end
                    O_ADJ: begin
                        o_wait_r <= 7'h00;
                        if (o_track_r) begin
                            o_state_r <= O_WAIT;
                        end else begin
                            o_iter_r <= o_iter_r + 4'h1;
                            if (o_iter_r + 4'h1 >= o_max || ch_in_band == 2'b11) begin
                                o_state_r <= O_HOLD; // [R5]
                            end else begin
                                o_state_r <= O_WAIT;
                            end
                        end
                    end
                    default: begin
                        o_state_r <= O_IDLE;
                    end
                endcase
            end
        end
    end

    always @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            dac_i_coarse_out <= 5'h00;
            dac_i_fine_out <= 5'h00;
            dac_q_coarse_out <= 5'h00;
            dac_q_fine_out <= 5'h00;
        end else begin
            dac_i_coarse_out <= dac_w[9:5]; // [R10]
            dac_i_fine_out <= dac_w[4:0]; // [R10]
            dac_q_coarse_out <= dac_w[19:15]; // [R10]
            dac_q_fine_out <= dac_w[14:10]; // [R10]
        end
    end

    // -----------------------------------------------------------------------
    // Level loop control.
    // -----------------------------------------------------------------------
    localparam L_IDLE = 2'd0;
    localparam L_SKIP = 2'd1;
    localparam L_ACC = 2'd2;
    localparam L_EVAL = 2'd3;

    reg [1:0] l_state_r;
    reg l_track_r;
    reg [5:0] l_cnt_r;
    reg [15:0] l_acc_r;
    reg det_r;
    wire [2:0] l_shift = `RDC_AVG_BASE_LOG2 + (l_track_r ? l_trk : l_init); // [R14] [R15] [R19]
    wire [5:0] l_nsamp = 6'h01 << l_shift;
    wire [5:0] l_nskip = 6'h01 << l_skip; // [R16]
    wire [15:0] l_avg = l_acc_r >> l_shift;
    wire [15:0] l_hi = {6'h00, l_tgt} + {10'h000, l_hyst};
    wire [15:0] l_lo = ({6'h00, l_tgt} > {10'h000, l_hyst}) ? {6'h00, l_tgt} - {10'h000, l_hyst}
                                                              : 16'h0000;
    wire [6:0] det_th = lvl_ctrl_r[`RDC_LOVR_BIT] ? lvl_ctrl_r[`RDC_LOVAL_LSB +: 7]
                                                   : detect_threshold_auto_in; // [R13]

    always @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            l_state_r <= L_IDLE;
            l_track_r <= 1'b0;
            l_cnt_r <= 6'h00;
            l_acc_r <= 16'h0000;
            det_r <= 1'b0;
            gain_up_out <= 1'b0;
            gain_down_out <= 1'b0;
            gain_update_count_out <= 8'h00;
            demod_enable_out <= 1'b0;
            detect_threshold_out <= 7'h00;
        end else begin
            gain_up_out <= 1'b0;
            gain_down_out <= 1'b0;
            detect_threshold_out <= det_th;
            demod_enable_out <= lvl_ctrl_r[`RDC_LDEMOD_BIT] || det_r; // [R11]
            if (!rx_active_in) begin
                l_state_r <= L_IDLE;
                det_r <= 1'b0;
            end else begin
                case (l_state_r)
                    L_IDLE: begin
                        l_track_r <= 1'b0;
                        l_cnt_r <= 6'h00;
                        l_state_r <= L_SKIP;
                    end
                    L_SKIP: begin
                        if (level_valid_in) begin
                            l_cnt_r <= l_cnt_r + 6'h01;
                            if (l_cnt_r == l_nskip - 6'h01) begin
                                l_cnt_r <= 6'h00;
                                l_acc_r <= 16'h0000;
                                l_state_r <= L_ACC; // [R16]
                            end
                        end
                    end
                    L_ACC: begin
                        if (level_valid_in) begin
                            l_acc_r <= l_acc_r + {6'h00, level_in};
                            l_cnt_r <= l_cnt_r + 6'h01;
                            if (l_cnt_r == l_nsamp - 6'h01) begin
                                l_state_r <= L_EVAL;
                            end
                        end
                    end
                    L_EVAL: begin
                        det_r <= l_avg >= {9'h000, det_th};
                        if (l_avg > l_hi) begin
                            gain_down_out <= 1'b1; // [R17]
                        end else if (l_avg < l_lo) begin
                            gain_up_out <= 1'b1; // [R17]
                        end
                        if ((l_avg > l_hi || l_avg < l_lo) && gain_update_count_out != 8'hff) begin
                            gain_update_count_out <= gain_update_count_out + 8'h01;
                        end
                        l_track_r <= 1'b1;
                        l_cnt_r <= 6'h00;
                        l_acc_r <= 16'h0000;
                        l_state_r <= L_ACC;
                    end
                    default: begin
                        l_state_r <= L_IDLE;
                    end
                endcase
            end
            if (rx_rise || lvl_ctrl_r[`RDC_LCNTZ_BIT]) begin
                gain_update_count_out <= 8'h00; // [R12]
            end
        end
    end

    // -----------------------------------------------------------------------
    // Status readback.
    // -----------------------------------------------------------------------
    assign status_w = {2'b00, gain_update_count_out, det_r, (o_state_r == O_HOLD), dac_w};

endmodule
`default_nettype wire

// ### verification/rdc_loops_monitor.sv
// Bus handshake and level-step checks on the loop block ports.
`default_nettype none
module rdc_loops_mon (
    input wire logic clk_in, reset_n_in, s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in,
    input wire logic s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in,
    input wire logic s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in, gain_up_out,
    input wire logic gain_down_out, input wire logic [1:0] s_axi_bresp_out, // Watched ports.
    input wire logic [31:0] s_axi_rdata_out // Read data.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence w_go;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence b_wait; s_axi_bvalid_out && !s_axi_bready_in; endsequence
    sequence r_wait; s_axi_rvalid_out && !s_axi_rready_in; endsequence
    a_write_answer: assert property (w_go |-> ##2 s_axi_bvalid_out) else $error("no bvalid");
    a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("no rvalid");
    a_bresp_hold: assert property (b_wait |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("bresp lost");
    a_rdata_hold: assert property (r_wait |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("rdata lost");
    a_read_refused: assert property (s_axi_rvalid_out |-> !s_axi_arready_out) else $error("ar");
    a_write_refused: assert property (w_go |=> !s_axi_awready_out) else $error("aw");
    a_gain_pulse: assert property (gain_up_out |=> !gain_up_out) else $error("gain");
    a_gain_apart: assert property (!(gain_up_out && gain_down_out)) else $error("gain");
endmodule
bind rdc_rx_loops rdc_loops_mon mon_u (.*);
`default_nettype wire

// ### verification/rdc_afe_model.sv
// Front-end stand-in: ADC samples from the DAC codes, level samples from a set value.
`default_nettype none
module rdc_afe_model (
    input wire logic clk_in, input wire logic [19:0] dac_in, // Clock, Q and I DAC codes.
    input wire logic [9:0] level_set_in, // Level to report.
    output logic [19:0] adc_iq_out, output logic [9:0] level_out, output logic strobe_out // Samples.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph = 2'h0;
    initial {adc_iq_out, level_out, strobe_out} = 31'h0;
    always @(posedge clk_in) begin
        ph <= ph + 2'h1;
        strobe_out <= ph == 2'h0;
        adc_iq_out <= ph == 2'h0 ? 20'h08020 - dac_in : ~adc_iq_out;
        level_out <= ph == 2'h0 ? level_set_in : ~level_set_in;
    end
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the receiver loop control block.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'h0, reset_n_in = 1'h0, s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0;
    logic s_axi_bready_in = 1'h0, s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0;
    logic rx_active_in = 1'h0, card_response_in = 1'h0, dyn_threshold_write_in = 1'h0;
    logic automatic_receiver_control_on_in = 1'h0, s_axi_awready_out, s_axi_wready_out;
    logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, adc_valid_in, level_valid_in;
    logic demod_enable_out, gain_up_out, gain_down_out;
    logic [1:0] s_axi_rresp_out, s_axi_bresp_out;
    logic [4:0] dac_i_coarse_out, dac_i_fine_out, dac_q_coarse_out, dac_q_fine_out;
    logic [6:0] detect_threshold_auto_in = 7'h33, dyn_threshold_in = 7'h22, detect_threshold_out;
    logic [7:0] gain_update_count_out;
    logic [9:0] level_in;
    logic [11:0] s_axi_awaddr_in = 12'h0, s_axi_araddr_in = 12'h0;
    logic [19:0] adc_iq_in;
    logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
    logic [3:0] s_axi_wstrb_in = 4'hf;
    int err_count = 0, total_checks = 0;
    always #2 clk_in = ~clk_in;
    assign level_valid_in = adc_valid_in;
    rdc_rx_loops dut_u (.*);
    rdc_afe_model afe_u (.clk_in(clk_in), .level_set_in(10'h200), .adc_iq_out(adc_iq_in),
        .dac_in({dac_q_coarse_out, dac_q_fine_out, dac_i_coarse_out, dac_i_fine_out}),
        .level_out(level_in), .strobe_out(adc_valid_in));
    task automatic complete_run(input int extra);
        err_count += extra;
        if (err_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        err_count += int'(got !== exp);
        if (got !== exp) $display("MISMATCH %0t %h %h", $time, got, exp);
    endtask
    function automatic logic seen(input int k);
        return k == 0 ? s_axi_awready_out & s_axi_wready_out : k == 1 ? s_axi_arready_out :
            k == 2 ? s_axi_bvalid_out : k == 3 ? s_axi_rvalid_out : gain_up_out;
    endfunction
    task automatic waitfor(input int k);
        for (int n = 0; seen(k) !== 1'h1; n++) begin
            if (n == 300) complete_run(1);
            @(negedge clk_in);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] r);
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} <= {a, a, d};
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_arvalid_in} <= {w, w, !w};
        @(negedge clk_in);
        waitfor(w ? 0 : 1);
        @(posedge clk_in);
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_arvalid_in} <= 3'h0;
        {s_axi_bready_in, s_axi_rready_in} <= {w, !w};
        @(negedge clk_in);
        waitfor(w ? 2 : 3);
        if (!w) chk(s_axi_rdata_out, d);
        chk(w ? s_axi_bresp_out : s_axi_rresp_out, r);
        @(posedge clk_in);
        {s_axi_bready_in, s_axi_rready_in} <= 2'h0;
    endtask
    task automatic t_regs();
        xfer(1'h0, 12'h0b8, 32'h0, 2'h0);
        xfer(1'h0, 12'h0c0, 32'h0, 2'h0);
        xfer(1'h1, 12'h0b8, 32'hf3f56ba5, 2'h0);
        xfer(1'h0, 12'h0b8, 32'hf3f56ba5, 2'h0);
        xfer(1'h0, 12'h0bc, 32'h00156ba5, 2'h0);
        xfer(1'h1, 12'h0c4, 32'h1, 2'h2);
        xfer(1'h0, 12'h0c4, 32'h0, 2'h2);
        chk({dac_q_coarse_out, dac_q_fine_out, dac_i_coarse_out, dac_i_fine_out},
            20'h56ba5);
    endtask
    task automatic t_level();
        xfer(1'h1, 12'h0c0, 32'he0098055, 2'h0);
        rx_active_in <= 1'h1;
        waitfor(4);
        @(negedge clk_in);
        chk({gain_down_out, demod_enable_out, gain_update_count_out, detect_threshold_out},
            17'h08055);
        @(posedge clk_in);
        xfer(1'h1, 12'h0c0, 32'h00088000, 2'h0);
        automatic_receiver_control_on_in <= 1'h1;
        dyn_threshold_write_in <= 1'h1;
        @(posedge clk_in);
        dyn_threshold_write_in <= 1'h0;
        chk(detect_threshold_out, 7'h33);
        xfer(1'h0, 12'h0c0, 32'h00088022, 2'h0);
    endtask
    initial begin
        repeat (6) @(posedge clk_in);
        reset_n_in <= 1'h1;
        repeat (3) @(posedge clk_in);
        t_regs();
        t_level();
        complete_run(0);
    end
endmodule
`default_nettype wire
